// [src/parser_pkg.sv]
// constants and carrier types for the remote command parser
package parser_pkg;
	// --------------------------------------------------
	// sizes
	// --------------------------------------------------
	localparam int BUF_DEPTH = 100;
	localparam int LEN_W = 7;
	localparam int ESR_CMD_ERR_BIT = 5;
	localparam logic [2:0] BOOL_MAX = 3'h4;
	localparam logic [3:0] MEAS_LEN = 4'hE;
	localparam logic [3:0] ERR_LEN = 4'hA;
	// --------------------------------------------------
	// characters
	// --------------------------------------------------
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_TAB = 8'h09;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_SEMI = 8'h3B;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_QMARK = 8'h3F;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_1 = 8'h31;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_LA = 8'h61;
	localparam logic [7:0] CH_LZ = 8'h7A;
	localparam logic [7:0] CASE_BIT = 8'h20;
	localparam logic [15:0] WORD_ON = 16'h4F4E;
	localparam logic [23:0] WORD_OFF = 24'h4F4646;
	// fixed error response, sign first, linefeed last
	localparam logic [79:0] ERR_STR = 80'h2B392E3930452B33370A;
	// --------------------------------------------------
	// types
	// --------------------------------------------------
	typedef enum logic {PH_KEY, PH_PARAM} phase_t;
	typedef enum logic [3:0] {N_START, N_SIGN, N_INT, N_DOT0, N_DOT, N_FRAC, N_E, N_ESIGN,
		N_EXP, N_BAD} num_t;
	typedef struct packed {
		logic [7:0] data;
		logic eoi;
	} rx_byte_t;
	typedef struct packed {
		logic [LEN_W-1:0] len;
		logic query;
		logic err;
		logic [LEN_W-1:0] nparams;
		logic [3:0] depth;
		logic bool_ok;
		logic bool_val;
		logic num_ok;
	} msg_info_t;
	typedef struct packed {
		logic neg;
		logic [6:0][3:0] mant;
		logic exp_neg;
		logic [1:0][3:0] expd;
	} meas_t;
endpackage

// [src/remote_command_parser.sv]
// remote command parser: message buffer, syntax checks, response formatter
// How it works
// - bytes with attention negated go to parser
// - polled and addressed to talk: send status byte
// - leading colon sets command error bit
// - semicolon sets command error bit
// - missing keyword separator sets command error
// - whitespace inside parameters sets command error
// - surplus parameters dropped without error
// - keywords matched case blind, replies upper case
// - booleans OFF 0 ON 1, decoded to bool_ok and bool_val
// - decimal numbers with exponent, no unit suffix
// - reply only to queries unless talk only
// - measurement reply fixed form, EOI with linefeed
// - errored query replies with fixed error value
// - serial ends at LF or CR, CR-LF once
// - IEEE ends at LF or EOI byte
// - every terminator returns path to root
// - hundred slot buffer holding 99 characters, run after terminator
// - powers up local; return-to-local restores it
`timescale 1ns/1ps
module remote_command_parser #(
	parameter int BUF_DEPTH = parser_pkg::BUF_DEPTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// link mode and bus state
	input wire logic ieee_mode_i,
	input wire logic talk_only_i,
	input wire logic atn_i,
	input wire logic spoll_i,
	input wire logic talk_i,
	input wire logic [7:0] status_byte_i,
	// received byte stream
	input wire logic rx_valid_i,
	input wire parser_pkg::rx_byte_t rx_i,
	output logic rx_ready_o,
	// message handed to the executor
	output logic msg_valid_o,
	output parser_pkg::msg_info_t msg_o,
	input wire logic msg_ack_i,
	input wire logic [parser_pkg::LEN_W-1:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	// command error event
	output logic cmd_err_o,
	output logic [7:0] esr_o,
	input wire logic esr_clear_i,
	// responses
	input wire logic resp_req_i,
	input wire logic resp_err_i,
	input wire parser_pkg::meas_t meas_i,
	output logic resp_ready_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_eoi_o,
	input wire logic tx_ready_i,
	// local and remote state
	input wire logic go_local_i,
	input wire logic go_remote_i,
	output logic local_o
);
	import parser_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] to_upper(input logic [7:0] ch);
		return (ch >= CH_LA && ch <= CH_LZ) ? (ch & ~CASE_BIT) : ch;
	endfunction

	function automatic logic is_digit(input logic [7:0] ch);
		return ch >= CH_0 && ch <= CH_9;
	endfunction

	function automatic logic is_ws(input logic [7:0] ch);
		return ch == CH_TAB || ch == CH_SP;
	endfunction

	function automatic logic is_sign(input logic [7:0] ch);
		return ch == CH_PLUS || ch == CH_MINUS;
	endfunction

	// one step of the decimal number recogniser
	function automatic num_t num_step(input num_t s, input logic [7:0] ch);
		num_t n;
		n = N_BAD;
		case (s)
			N_START: n = is_sign(ch) ? N_SIGN : is_digit(ch) ? N_INT : ch == CH_DOT ? N_DOT0 : N_BAD;
			N_SIGN: n = is_digit(ch) ? N_INT : ch == CH_DOT ? N_DOT0 : N_BAD;
			N_INT: n = is_digit(ch) ? N_INT : ch == CH_DOT ? N_DOT : ch == CH_E ? N_E : N_BAD;
			N_DOT0: n = is_digit(ch) ? N_FRAC : N_BAD;
			N_DOT, N_FRAC: n = is_digit(ch) ? N_FRAC : ch == CH_E ? N_E : N_BAD;
			N_E: n = is_sign(ch) ? N_ESIGN : is_digit(ch) ? N_EXP : N_BAD;
			N_ESIGN, N_EXP: n = is_digit(ch) ? N_EXP : N_BAD;
			default: n = N_BAD;
		endcase
		return n;
	endfunction

	// character of a reply at a given position
	function automatic logic [7:0] fmt_char(input meas_t m, input logic e, input logic [3:0] i);
		logic [7:0] r;
		r = CH_LF;
		if (e) begin
			r = ERR_STR[(32'(ERR_LEN) - 1 - 32'(i)) * 8 +: 8];
		end else begin
			case (i)
				4'h0: r = m.neg ? CH_MINUS : CH_PLUS;
				4'h1, 4'h2, 4'h3, 4'h4: r = CH_0 + {4'h0, m.mant[3'(4'h7 - i)]};
				4'h5: r = CH_DOT;
				4'h6, 4'h7, 4'h8: r = CH_0 + {4'h0, m.mant[3'(4'h8 - i)]};
				4'h9: r = CH_E;
				4'hA: r = m.exp_neg ? CH_MINUS : CH_PLUS;
				4'hB: r = CH_0 + {4'h0, m.expd[1]};
				4'hC: r = CH_0 + {4'h0, m.expd[0]};
				default: r = CH_LF;
			endcase
		end
		return r;
	endfunction

	// ----------------------------------------
	// receive side
	// ----------------------------------------
	logic atn_meta, atn_sync, after_cr, ovf, err_acc, query_acc, full;
	logic accept, is_lf, skip, store, done;
	logic [7:0] c;
	logic [7:0] buffer [BUF_DEPTH];
	logic [LEN_W-1:0] wr_ptr, nparams, next_nparams;
	logic [3:0] depth, next_depth;
	logic [23:0] bchars, next_bchars;
	logic [2:0] blen, next_blen;
	logic next_err, next_query, next_ovf;
	phase_t phase, next_phase;
	num_t num, next_num;

	// attention pin synchroniser
	always_ff @(posedge clk_i) begin
		atn_meta <= atn_i;
		atn_sync <= atn_meta;
	end

	assign accept = rx_valid_i && rx_ready_o && !(ieee_mode_i && atn_sync);
	assign c = to_upper(rx_i.data);
	assign is_lf = rx_i.data == CH_LF;
	assign skip = !ieee_mode_i && is_lf && after_cr;
	assign store = accept && !is_lf && (ieee_mode_i || rx_i.data != CH_CR);
	assign done = accept && !skip && (ieee_mode_i ? (is_lf || rx_i.eoi)
		: (is_lf || rx_i.data == CH_CR));
	assign full = wr_ptr >= LEN_W'(BUF_DEPTH - 1); // last slot is the terminator's

	// syntax checks on each stored character
	always_comb begin
		next_err = err_acc;
		next_ovf = ovf;
		next_phase = phase;
		next_query = query_acc;
		next_nparams = nparams;
		next_depth = depth;
		next_num = num;
		next_bchars = bchars;
		next_blen = blen;
		if (store && full) begin
			next_ovf = 1'b1;
		end else if (store) begin
			if (wr_ptr == '0 && c == CH_COLON)
				next_err = 1'b1;
			if (c == CH_SEMI)
				next_err = 1'b1;
			if (phase == PH_KEY) begin
				if (c == CH_COLON)
					next_depth = depth + 4'h1;
				if (is_ws(c)) begin
					next_phase = PH_PARAM;
				end else begin
					// the separator must not hide a trailing question mark
					next_query = c == CH_QMARK;
					if (is_digit(c) || is_sign(c) || c == CH_DOT || c == CH_COMMA)
						next_err = 1'b1;
				end
			end else if (is_ws(c)) begin
				next_err = 1'b1;
			end else if (c == CH_COMMA) begin
				next_nparams = nparams + 1'b1;
			end else if (nparams == '0) begin
				next_num = num_step(num, c);
				if (blen != BOOL_MAX) begin
					next_bchars = {bchars[15:0], c};
					next_blen = blen + 3'h1;
				end
			end
		end
	end

	// parse state, cleared to root by every terminator
	always_ff @(posedge clk_i) begin
		if (!nrst_i || done) begin
			err_acc <= 1'b0;
			ovf <= 1'b0;
			phase <= PH_KEY;
			query_acc <= 1'b0;
			nparams <= '0;
			depth <= '0;
			num <= N_START;
			bchars <= '0;
			blen <= '0;
		end else begin
			err_acc <= next_err;
			ovf <= next_ovf;
			phase <= next_phase;
			query_acc <= next_query;
			nparams <= next_nparams;
			depth <= next_depth;
			num <= next_num;
			bchars <= next_bchars;
			blen <= next_blen;
		end
	end

	// carriage return memory for the serial link
	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			after_cr <= 1'b0;
		else if (accept)
			after_cr <= !ieee_mode_i && rx_i.data == CH_CR;
	end

	// input buffer storage, upper-cased
	always_ff @(posedge clk_i) begin
		if (store && !full)
			buffer[wr_ptr] <= c;
	end

	// write pointer
	always_ff @(posedge clk_i) begin
		if (!nrst_i || done)
			wr_ptr <= '0;
		else if (store && !full)
			wr_ptr <= wr_ptr + 1'b1;
	end

	// buffer read port for the executor
	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			rd_data_o <= '0;
		else
			rd_data_o <= (32'(rd_addr_i) < BUF_DEPTH) ? buffer[rd_addr_i] : '0;
	end

	// message hand-over; input stalls until the executor takes it
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			msg_valid_o <= 1'b0;
			rx_ready_o <= 1'b1;
			msg_o <= '0;
		end else if (done) begin
			msg_valid_o <= 1'b1;
			rx_ready_o <= 1'b0;
			msg_o.len <= (store && !full) ? wr_ptr + 1'b1 : wr_ptr;
			msg_o.query <= next_query;
			msg_o.err <= next_err || next_ovf;
			msg_o.nparams <= (next_phase == PH_PARAM) ? next_nparams + 1'b1 : '0;
			msg_o.depth <= next_depth;
			msg_o.bool_ok <= (next_blen == 3'h1 && (next_bchars[7:0] == CH_0
				|| next_bchars[7:0] == CH_1)) || (next_blen == 3'h2
				&& next_bchars[15:0] == WORD_ON) || (next_blen == 3'h3
				&& next_bchars == WORD_OFF);
			msg_o.bool_val <= (next_blen == 3'h1 && next_bchars[7:0] == CH_1)
				|| (next_blen == 3'h2 && next_bchars[15:0] == WORD_ON);
			msg_o.num_ok <= next_num == N_INT || next_num == N_DOT || next_num == N_FRAC
				|| next_num == N_EXP;
		end else if (msg_valid_o && msg_ack_i) begin
			msg_valid_o <= 1'b0;
			rx_ready_o <= 1'b1;
		end
	end

	// command error pulse and sticky event bit; a set beats a clear
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cmd_err_o <= 1'b0;
			esr_o <= '0;
		end else begin
			cmd_err_o <= done && (next_err || next_ovf);
			esr_o[ESR_CMD_ERR_BIT] <= (done && (next_err || next_ovf))
				|| (esr_o[ESR_CMD_ERR_BIT] && !esr_clear_i);
		end
	end

	// ----------------------------------------
	// response side
	// ----------------------------------------
	logic tx_busy, tx_err, pend_query, poll, poll_q, auto_err, take_resp, load, adv, last;
	logic next_busy, next_pend, next_tx_err;
	logic [3:0] tx_idx, next_idx;
	meas_t meas_q, next_meas;

	assign poll = ieee_mode_i && spoll_i && talk_i;
	assign auto_err = msg_valid_o && msg_ack_i && msg_o.query && msg_o.err;
	assign take_resp = resp_req_i && resp_ready_o && !auto_err;
	assign load = !tx_busy && (auto_err || take_resp);
	assign adv = tx_valid_o && tx_ready_i && !poll_q;
	assign last = tx_idx == (tx_err ? ERR_LEN : MEAS_LEN) - 4'h1;
	assign next_busy = load || (tx_busy && !(adv && last));
	assign next_idx = load ? 4'h0 : (adv && !last) ? tx_idx + 4'h1 : tx_idx;
	assign next_meas = take_resp ? meas_i : meas_q;
	assign next_tx_err = load ? (auto_err || resp_err_i) : tx_err;
	assign next_pend = (msg_valid_o && msg_ack_i) ? (msg_o.query && !msg_o.err)
		: (load ? 1'b0 : pend_query);

	// formatter state
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			tx_busy <= 1'b0;
			tx_idx <= '0;
			tx_err <= 1'b0;
			meas_q <= '0;
			pend_query <= 1'b0;
			poll_q <= 1'b0;
		end else begin
			tx_busy <= next_busy;
			tx_idx <= next_idx;
			tx_err <= next_tx_err;
			meas_q <= next_meas;
			pend_query <= next_pend;
			poll_q <= poll;
		end
	end

	// output character register; status byte takes over while polled
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			tx_valid_o <= 1'b0;
			tx_data_o <= '0;
			tx_eoi_o <= 1'b0;
			resp_ready_o <= 1'b0;
		end else begin
			tx_valid_o <= next_busy || poll;
			tx_data_o <= poll ? status_byte_i : fmt_char(next_meas, next_tx_err, next_idx);
			tx_eoi_o <= !poll && next_busy && ieee_mode_i
				&& fmt_char(next_meas, next_tx_err, next_idx) == CH_LF;
			resp_ready_o <= !next_busy && (next_pend || talk_only_i);
		end
	end

	// local mode from power-up; remote only on request
	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			local_o <= 1'b1;
		else if (go_local_i)
			local_o <= 1'b1;
		else if (go_remote_i)
			local_o <= 1'b0;
	end
endmodule // remote_command_parser

// [verif/controller_model.sv]
// remote controller model: sends messages, consumes replies
`timescale 1ns/1ps
module controller_model (
	// clock
	input wire logic clk_i,
	// bytes to the parser
	output logic rx_valid_o,
	output parser_pkg::rx_byte_t rx_o,
	input wire logic rx_ready_i,
	// reply bytes from the parser
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_eoi_i,
	output logic tx_ready_o
);
	import parser_pkg::*;
	logic stall = 1'b0;
	logic [1:0] tick = 2'h0;
	logic [8:0] got[$];
	initial begin
		rx_valid_o = 1'b0;
		rx_o = 9'h1FE;
		tx_ready_o = 1'b0;
	end
	// offer each character until taken; wait out a reply first
	task automatic send(input string s, input logic eoi);
		while (tx_valid_i === 1'b1) @(posedge clk_i);
		for (int i = 0; i < s.len(); i++) begin
			@(negedge clk_i);
			rx_o = {s[i], eoi && i == s.len() - 1};
			rx_valid_o = 1'b1;
			do @(posedge clk_i); while (rx_ready_i !== 1'b1);
		end
		@(negedge clk_i);
		rx_valid_o = 1'b0;
		rx_o = ~rx_o; // released line shows no stale byte
	endtask
	// accept replies, only one cycle in four while stalling
	always @(negedge clk_i) begin
		tick <= tick + 2'h1;
		tx_ready_o <= !stall || tick == 2'h3;
	end
	// record each reply byte at its handshake
	always @(posedge clk_i) begin
		if (tx_valid_i === 1'b1 && tx_ready_o) got.push_back({tx_data_i, tx_eoi_i});
	end
endmodule // controller_model

// [verif/remote_command_parser_chk.sv]
// port assertions for the remote command parser
`timescale 1ns/1ps
module remote_command_parser_chk #(
	parameter int BUF_DEPTH = 100
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// bus state
	input wire logic ieee_mode_i,
	input wire logic atn_i,
	input wire logic spoll_i,
	input wire logic talk_i,
	input wire logic [7:0] status_byte_i,
	// receive stream and message
	input wire logic rx_valid_i,
	input wire parser_pkg::rx_byte_t rx_i,
	input wire logic rx_ready_o,
	input wire logic msg_valid_o,
	input wire parser_pkg::msg_info_t msg_o,
	input wire logic msg_ack_i,
	// command error
	input wire logic cmd_err_o,
	input wire logic [7:0] esr_o,
	input wire logic esr_clear_i,
	// replies and local state
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_eoi_o,
	input wire logic go_local_i,
	input wire logic go_remote_i,
	input wire logic local_o
);
	import parser_pkg::*;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// terminators, buffering and attention
	a_serial_cr_end: assert property (
		!ieee_mode_i && rx_valid_i && rx_ready_o && rx_i.data == CH_CR |=> msg_valid_o && !rx_ready_o)
		else $error("serial CR did not end the message");
	a_ieee_end: assert property (
		ieee_mode_i && !atn_i && !$past(atn_i) && !$past(atn_i, 2) && rx_valid_i && rx_ready_o
		&& (rx_i.eoi || rx_i.data == CH_LF) |=> msg_valid_o)
		else $error("IEEE terminator did not end the message");
	a_atn_ignore: assert property (
		ieee_mode_i && atn_i && $past(atn_i) && $past(atn_i, 2) && !msg_valid_o && rx_valid_i
		&& (rx_i.eoi || rx_i.data == CH_LF) |=> !msg_valid_o)
		else $error("byte taken while attention asserted");
	a_msg_hold: assert property (
		msg_valid_o && !msg_ack_i |=> msg_valid_o && $stable(msg_o) && !rx_ready_o)
		else $error("message not held until acknowledged");
	// command error reporting
	a_err_flag: assert property (
		cmd_err_o |-> msg_valid_o && msg_o.err)
		else $error("error pulse without flagged message");
	a_err_sticky: assert property (
		cmd_err_o && !esr_clear_i |=> esr_o[ESR_CMD_ERR_BIT] && esr_o[7:6] == 2'h0 && esr_o[4:0] == 5'h00)
		else $error("event register not set by command error");
	// reply stream
	a_eoi_lf: assert property (
		tx_valid_o && tx_eoi_o |-> tx_data_o == CH_LF && ieee_mode_i)
		else $error("end marker not on IEEE linefeed");
	a_poll_status: assert property (
		ieee_mode_i && spoll_i && talk_i |=> tx_valid_o && tx_data_o == $past(status_byte_i) && !tx_eoi_o)
		else $error("status byte not returned under poll");
	// local and remote
	a_local_wins: assert property (
		go_local_i |=> local_o)
		else $error("return to local ignored");
	a_remote_go: assert property (
		go_remote_i && !go_local_i |=> !local_o)
		else $error("remote request ignored");
	// main scenarios
	c_err: cover property (cmd_err_o);
	c_query: cover property (msg_valid_o && msg_o.query);
	c_eoi: cover property (tx_valid_o && tx_eoi_o);
endmodule // remote_command_parser_chk

bind remote_command_parser remote_command_parser_chk #(.BUF_DEPTH(BUF_DEPTH)) chk_u (.clk_i,
	.nrst_i, .ieee_mode_i, .atn_i, .spoll_i, .talk_i, .status_byte_i, .rx_valid_i, .rx_i,
	.rx_ready_o, .msg_valid_o, .msg_o, .msg_ack_i, .cmd_err_o, .esr_o, .esr_clear_i, .tx_valid_o,
	.tx_data_o, .tx_eoi_o, .go_local_i, .go_remote_i, .local_o);

// [verif/test_remote_command_parser.sv]
// self-checking bench for the remote command parser
`timescale 1ns/1ps
module test_remote_command_parser;
	import parser_pkg::*;
	logic clk = 0, nrst = 0, ieee = 0, tonly = 0, atn = 0, spoll = 0, talk = 0;
	logic rx_valid, rx_ready, msg_valid, ack = 0, cmd_err, esr_clr = 0, req = 0, rerr = 0;
	logic resp_ready, tx_valid, tx_eoi, tx_ready, go_l = 0, go_r = 0, local_st;
	logic [7:0] sbyte = 8'hA5, rd_data, esr, tx_data;
	logic [6:0] rd_addr = 7'h00;
	rx_byte_t rx;
	msg_info_t msg;
	meas_t meas = '0;
	int err_count = 0, samples_checked = 0;
	remote_command_parser dut_u (.clk_i(clk), .nrst_i(nrst), .ieee_mode_i(ieee),
		.talk_only_i(tonly), .atn_i(atn), .spoll_i(spoll), .talk_i(talk), .status_byte_i(sbyte),
		.rx_valid_i(rx_valid), .rx_i(rx), .rx_ready_o(rx_ready), .msg_valid_o(msg_valid),
		.msg_o(msg), .msg_ack_i(ack), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
		.cmd_err_o(cmd_err), .esr_o(esr), .esr_clear_i(esr_clr), .resp_req_i(req),
		.resp_err_i(rerr), .meas_i(meas), .resp_ready_o(resp_ready), .tx_valid_o(tx_valid),
		.tx_data_o(tx_data), .tx_eoi_o(tx_eoi), .tx_ready_i(tx_ready), .go_local_i(go_l),
		.go_remote_i(go_r), .local_o(local_st));
	controller_model p_u (.clk_i(clk), .rx_valid_o(rx_valid), .rx_o(rx), .rx_ready_i(rx_ready),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_eoi_i(tx_eoi), .tx_ready_o(tx_ready));
	// 10 MHz clock
	always #50 clk = ~clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask
	// send a message and check it arrives whole
	task automatic run_msg(input string s, input logic eoi, input logic e, input int len);
		p_u.send(s, eoi);
		for (int k = 0; k < 50 && msg_valid !== 1'b1; k++) @(negedge clk);
		check({msg_valid, cmd_err, msg.err}, {1'b1, e, e});
		check(msg.len, len);
	endtask
	task automatic done();
		ack = 1'b1;
		cycles(1);
		ack = 1'b0;
		cycles(1);
	endtask
	// compare recorded reply bytes with the expected text
	task automatic reply(input string s, input logic eoi);
		for (int k = 0; k < 400 && p_u.got.size() < s.len(); k++) @(negedge clk);
		check(p_u.got.size(), s.len());
		foreach (p_u.got[i]) check(p_u.got[i], {s[i], eoi && i == s.len() - 1});
		p_u.got.delete();
	endtask
	task automatic t_syntax();
		string c[11] = '{":RANG 3\r", "ABOR;INIT\n", "RANG3\n", "CURR 10, AVE\r",
			"CURR 10,AVE,X\r", "INIT:CONT on\r", "INIT:CONT OFF\n", "X 1\n", "X 0\r",
			"RANG -3.5E-3\n", "RANG 3KOHM\r"};
		logic [3:0] w[11] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h1, 4'h6, 4'h4, 4'h7, 4'h5, 4'h1, 4'h0};
		for (int i = 0; i < 11; i++) begin
			run_msg(c[i], 1'b0, w[i][3], c[i].len() - 1);
			if (!w[i][3]) check({msg.bool_ok, msg.bool_val, msg.num_ok}, w[i][2:0]);
			if (i == 4) check(msg.nparams, 3);
			if (i == 5) check(msg.depth, 1);
			done();
			check({esr[ESR_CMD_ERR_BIT], resp_ready}, {w[i][3], 1'b0});
			esr_clr = 1'b1;
			cycles(1);
			esr_clr = 1'b0;
		end
	endtask
	task automatic t_crlf();
		run_msg("AB\r", 1'b0, 1'b0, 2);
		done();
		p_u.send("\n", 1'b0);
		cycles(4);
		check(msg_valid, 0);
		run_msg("C\n", 1'b0, 1'b0, 1);
		done();
	endtask
	task automatic t_buffer();
		string s = "";
		repeat (BUF_DEPTH - 1) s = {s, "a"};
		p_u.send(s, 1'b0);
		cycles(3);
		check(msg_valid, 0);
		run_msg("\n", 1'b0, 1'b0, BUF_DEPTH - 1);
		done();
		run_msg({s, "bb\n"}, 1'b0, 1'b1, BUF_DEPTH - 1);
		done();
		check(esr[ESR_CMD_ERR_BIT], 1);
	endtask
	task automatic t_meas();
		string up = "FETCH?";
		run_msg("fEtCh?\n", 1'b0, 1'b0, 6);
		check(msg.query, 1);
		for (int i = 0; i < 6; i++) begin
			rd_addr = i[6:0];
			cycles(1);
			check(rd_data, up[i]);
		end
		done();
		check(resp_ready, 1);
		meas = {1'b1, 28'h1234567, 1'b1, 8'h03};
		p_u.stall = 1'b1;
		req = 1'b1;
		cycles(1);
		req = 1'b0;
		reply("-1234.567E-03\n", 1'b0);
		p_u.stall = 1'b0;
	endtask
	task automatic t_ieee();
		ieee = 1'b1;
		atn = 1'b1;
		cycles(3);
		p_u.send("Z\n", 1'b0);
		cycles(3);
		check(msg_valid, 0);
		atn = 1'b0;
		cycles(3);
		run_msg("KY", 1'b1, 1'b0, 2);
		done();
		run_msg("B\n", 1'b1, 1'b0, 1);
		done();
		run_msg("A;B?\n", 1'b0, 1'b1, 4);
		check(msg.query, 1);
		done();
		reply("+9.90E+37\n", 1'b1);
		spoll = 1'b1;
		talk = 1'b1;
		cycles(2);
		check({tx_valid, tx_data, tx_eoi}, {1'b1, sbyte, 1'b0});
		{spoll, talk} = 2'b00;
		cycles(3);
		p_u.got.delete();
		ieee = 1'b0;
	endtask
	task automatic t_local();
		go_r = 1'b1;
		cycles(1);
		go_r = 1'b0;
		cycles(1);
		check(local_st, 0);
		{go_r, go_l} = 2'b11;
		cycles(1);
		{go_r, go_l} = 2'b00;
		cycles(1);
		check(local_st, 1);
		tonly = 1'b1;
		cycles(3);
		check(resp_ready, 1);
		// execution error in talk only mode sends the error value
		rerr = 1'b1;
		req = 1'b1;
		cycles(1);
		req = 1'b0;
		rerr = 1'b0;
		reply("+9.90E+37\n", 1'b0);
		tonly = 1'b0;
	endtask
	// main sequence
	initial begin
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		cycles(2);
		check({rx_ready, msg_valid, esr, tx_valid, local_st}, 12'h801);
		t_syntax();
		t_crlf();
		t_buffer();
		t_meas();
		t_ieee();
		t_local();
		stop_test();
	end
	// watchdog
	initial begin
		#2000000;
		err_count++;
		stop_test();
	end
endmodule // test_remote_command_parser
